// File: hw/mmds_cfg.svh
// latency, offset, field and constant macros of the arithmetic unit
`ifndef MMDS_CFG_SVH
`define MMDS_CFG_SVH
`define LAT_ONE        6'h01
`define LAT_MAC_MISS   6'h02
`define LAT_MUL64      6'h02
`define LAT_MAC64_HIT  6'h03
`define LAT_MAC64_MISS 6'h04
`define LAT_SATRND     6'h02
`define LAT_DIV        6'h13
`define LAT_DIV_REV1   6'h23
`define DIV_STEPS      6'h02
`define DIV_STEPS_REV1 6'h01
`define DIV_BITS       6'h20
`define RND_CONST      32'h0000_8000
`define ADDR_CTRL      12'h000
`define ADDR_STAT      12'h004
`define CTRL_REV1_BIT  0
`define STAT_Q_BIT     0
`define STAT_BUSY_BIT  1
`define STAT_ACCV_BIT  2
`define CTRL_RST       1'h0
`endif

// File: hw/mmds_pkg.sv
// types shared by the arithmetic unit and its users
package mmds_pkg;
  typedef enum logic [4:0] {
    op_mul, op_mulhh, op_mulnhh, op_mulwh, op_mulnwh, op_mulrndhh,
    op_mulsathh_h, op_mulsathh_w, op_mulsatwh_w, op_mulsatrndhh_h, op_mulsatrndwh_w,
    op_mac, op_machh_w, op_machh_d, op_macwh_d, op_macsathh_w,
    op_macs_d, op_macu_d, op_muls_d, op_mulu_d, op_divs, op_divu,
    op_satadd_h, op_satadd_w, op_satsub_h, op_satsub_w,
    op_satrnds, op_satrndu, op_sats, op_satu
  } op_t;
  typedef enum logic [1:0] {st_idle, st_wait, st_div} state_t;
  typedef struct packed {
    op_t         op;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] acc;
    logic [3:0]  acc_idx;
    logic        part_x;
    logic        part_y;
    logic [4:0]  shift_amount;
    logic [4:0]  saturate_bit_field;
  } req_t;
  typedef struct packed {
    logic [63:0] value;
  } res_t;
endpackage

// File: hw/mul_mac_div_sat_unit.sv
// multiply, multiply-accumulate, divide and saturate unit of the execute stage
// How it works
// - ordinary multiplies use one array pass, giving 32- or 48-bit products
// - rounding halfword multiply adds 0x8000 to the raw product
// - multiplies leave flags alone; saturating fractional ones set the saturation flag
// - halfword multiply and negated form: signed 16x16 to 32, one cycle
// - word-by-halfword multiply and negated form: signed 32x16 to 48, one cycle
// - fractional saturating multiplies give 16/32-bit results, the rounding forms rounding first, one cycle
// - multiply-accumulate adds product to accumulator and returns the sum
// - accumulator cache hit issues in one cycle, miss costs one more
// - accumulates leave flags alone except saturating halfword accumulate
// - halfword accumulate into 32 or 48 bits, word-halfword into 48 bits
// - 64-bit multiplies take two array passes and two cycles
// - 64-bit accumulates take three cycles on cache hit, four otherwise
// - divide gives 32-bit quotient and remainder in 19 cycles
// - first-revision mode makes each divide take 35 cycles
// - divide is abandoned at once while an interrupt is pending
// - saturating add and subtract on halfwords and words, one cycle
// - rounding saturate shifts right with rounding then clamps, two cycles
// - plain saturate shifts then clamps to the selected width, one cycle
`timescale 1ns/10ps
`include "mmds_cfg.svh"
module mul_mac_div_sat_unit
  import mmds_pkg::*;
(
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        op_valid,
  input  req_t        op_req,
  input  logic        irq_pending,
  input  logic        acc_invalidate,
  output logic        busy,
  output logic        result_valid,
  output res_t        result,
  output logic        q_flag,
  output logic        q_set,
  output logic        div_abort
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // state and decode
  // ****************************************
  state_t      st_reg;
  req_t        req_reg;
  logic [63:0] acc_reg, acc_cache_reg, fast_res;
  logic [49:0] plo_reg;
  logic [5:0]  cnt_reg, lat_sel, div_cyc_reg;
  logic [3:0]  acc_idx_reg;
  logic        accv_reg, rev1_reg, fast_q, busy_reg, valid_reg, q_reg, qset_reg, abort_reg;
  res_t        result_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg;
  wire  idle  = (st_reg == st_idle);
  wire  take  = op_valid && idle;
  req_t cur;
  assign cur = idle ? op_req : req_reg;
  wire  is_mac = cur.op inside {op_mac, op_machh_w, op_machh_d, op_macwh_d,
                                op_macsathh_w, op_macs_d, op_macu_d};
  wire  is_div = cur.op inside {op_divs, op_divu};
  wire  hit    = accv_reg && (acc_idx_reg == op_req.acc_idx);
  wire [63:0] acc_src = hit ? acc_cache_reg : op_req.acc;
  wire [63:0] acc_cur = idle ? acc_src : acc_reg;
  // ****************************************
  // multiplier array
  // ****************************************
  wire [15:0] hx = cur.part_x ? cur.a[31:16] : cur.a[15:0];
  wire [15:0] hy = cur.part_y ? cur.b[31:16] : cur.b[15:0];
  wire signed [31:0] p_hh = $signed(hx) * $signed(hy);
  wire signed [47:0] p_wh = $signed(cur.a) * $signed(hy);
  wire [31:0] p_ww = cur.a * cur.b;
  wire sgn64 = cur.op inside {op_muls_d, op_macs_d};
  wire signed [32:0] ax  = {sgn64 & cur.a[31], cur.a};
  wire signed [16:0] blo = {1'h0, cur.b[15:0]};
  wire signed [16:0] bhi = {sgn64 & cur.b[31], cur.b[31:16]};
  wire signed [49:0] plo = ax * blo;
  wire signed [49:0] phi = ax * bhi;
  wire [63:0] p64 = 64'($signed(plo_reg)) + (64'(phi) << 16);
  // fractional forms; only min times min overflows
  wire hh_min = (hx == 16'h8000) && (hy == 16'h8000);
  wire wh_min = (cur.a == 32'h8000_0000) && (hy == 16'h8000);
  wire [31:0] f_hh  = {p_hh[30:0], 1'h0};
  wire [31:0] f_hhr = f_hh + `RND_CONST;
  wire [47:0] f_wh  = {p_wh[46:0], 1'h0};
  wire [47:0] f_whr = f_wh + {16'h0000, `RND_CONST};
  wire [31:0] fs_hh = hh_min ? 32'h7FFF_FFFF : f_hh;
  // ****************************************
  // saturating add, subtract and shift
  // ****************************************
  function automatic logic [32:0] sat32(input logic [32:0] s);
    sat32 = (s[32] != s[31]) ? {1'h1, s[32] ? 32'h8000_0000 : 32'h7FFF_FFFF} : {1'h0, s[31:0]};
  endfunction
  function automatic logic [16:0] sat16(input logic [16:0] s);
    sat16 = (s[16] != s[15]) ? {1'h1, s[16] ? 16'h8000 : 16'h7FFF} : {1'h0, s[15:0]};
  endfunction
  wire sub = cur.op inside {op_satsub_h, op_satsub_w};
  wire [32:0] aw = {cur.a[31], cur.a};
  wire [32:0] bw = {cur.b[31], cur.b};
  wire [16:0] al = {cur.a[15], cur.a[15:0]};
  wire [16:0] bl = {cur.b[15], cur.b[15:0]};
  wire [16:0] ah = {cur.a[31], cur.a[31:16]};
  wire [16:0] bh = {cur.b[31], cur.b[31:16]};
  wire [32:0] s_w  = sat32(sub ? aw - bw : aw + bw);
  wire [16:0] s_lo = sat16(sub ? al - bl : al + bl);
  wire [16:0] s_hi = sat16(sub ? ah - bh : ah + bh);
  wire [32:0] s_mac = sat32({acc_cur[31], acc_cur[31:0]} + {fs_hh[31], fs_hh});
  wire [4:0] sa  = cur.shift_amount;
  wire [5:0] nb  = (cur.saturate_bit_field == 5'h00) ? 6'h20 : {1'h0, cur.saturate_bit_field};
  wire rnd_op = cur.op inside {op_satrnds, op_satrndu};
  wire uns_op = cur.op inside {op_satrndu, op_satu};
  wire rbit   = rnd_op && (sa != 5'h00) && cur.a[sa - 5'h01];
  wire signed [33:0] shv = ($signed({{2{cur.a[31]}}, cur.a}) >>> sa)
                           + $signed({33'h0, rbit});
  wire [33:0] one = 34'h1;
  wire signed [33:0] smax = $signed((one << (nb - 6'h01)) - one);
  wire signed [33:0] hi_l = uns_op ? $signed((one << nb) - one) : smax;
  wire signed [33:0] lo_l = uns_op ? 34'sh0 : ~smax;
  wire sh_hi = shv > hi_l;
  wire sh_lo = shv < lo_l;
  wire [31:0] sh_v = sh_hi ? hi_l[31:0] : sh_lo ? lo_l[31:0] : shv[31:0];
  // ****************************************
  // result select
  // ****************************************
  always_comb
  begin
    fast_q = 1'h0;
    unique case (cur.op)
      op_mul:           fast_res = {32'h0, p_ww};
      op_mulhh:         fast_res = {32'h0, p_hh};
      op_mulnhh:        fast_res = {32'h0, -p_hh};
      op_mulwh:         fast_res = 64'(p_wh);
      op_mulnwh:        fast_res = 64'(-p_wh);
      op_mulrndhh:      fast_res = {32'h0, p_hh + `RND_CONST};
      op_mulsathh_h:    fast_res = {48'h0, hh_min ? 16'h7FFF : f_hh[31:16]};
      op_mulsatrndhh_h: fast_res = {48'h0, hh_min ? 16'h7FFF : f_hhr[31:16]};
      op_mulsathh_w:    fast_res = {32'h0, fs_hh};
      op_mulsatwh_w:    fast_res = {32'h0, wh_min ? 32'h7FFF_FFFF : f_wh[47:16]};
      op_mulsatrndwh_w: fast_res = {32'h0, wh_min ? 32'h7FFF_FFFF : f_whr[47:16]};
      op_mac:           fast_res = {32'h0, acc_cur[31:0] + p_ww};
      op_machh_w:       fast_res = {32'h0, acc_cur[31:0] + p_hh};
      op_machh_d:       fast_res = 64'($signed(acc_cur[47:0] + 48'(p_hh)));
      op_macwh_d:       fast_res = 64'($signed(acc_cur[47:0] + p_wh));
      op_macsathh_w:    fast_res = {32'h0, s_mac[31:0]};
      op_macs_d,
      op_macu_d:        fast_res = acc_cur + p64;
      op_muls_d,
      op_mulu_d:        fast_res = p64;
      op_divs,
      op_divu:          fast_res = 64'h0;
      op_satadd_h,
      op_satsub_h:      fast_res = {32'h0, s_hi[15:0], s_lo[15:0]};
      op_satadd_w,
      op_satsub_w:      fast_res = {32'h0, s_w[31:0]};
      op_satrnds,
      op_satrndu,
      op_sats,
      op_satu:          fast_res = {32'h0, sh_v};
      default:          fast_res = 64'h0;
    endcase
    unique case (cur.op)
      op_mulsathh_h, op_mulsathh_w, op_mulsatrndhh_h: fast_q = hh_min;
      op_mulsatwh_w, op_mulsatrndwh_w:                fast_q = wh_min;
      op_macsathh_w:                                  fast_q = hh_min | s_mac[32];
      op_satadd_h, op_satsub_h:                       fast_q = s_hi[16] | s_lo[16];
      op_satadd_w, op_satsub_w:                       fast_q = s_w[32];
      op_satrnds, op_satrndu, op_sats, op_satu:       fast_q = sh_hi | sh_lo;
      default:                                        fast_q = 1'h0;
    endcase
  end
  always_comb
  begin
    unique case (op_req.op)
      op_mac, op_machh_w, op_machh_d, op_macwh_d,
      op_macsathh_w:         lat_sel = hit ? `LAT_ONE : `LAT_MAC_MISS;
      op_macs_d, op_macu_d:  lat_sel = hit ? `LAT_MAC64_HIT : `LAT_MAC64_MISS;
      op_muls_d, op_mulu_d:  lat_sel = `LAT_MUL64;
      op_divs, op_divu:      lat_sel = rev1_reg ? `LAT_DIV_REV1 : `LAT_DIV;
      op_satrnds, op_satrndu: lat_sel = `LAT_SATRND;
      default:               lat_sel = `LAT_ONE;
    endcase
  end
  // ****************************************
  // divider
  // ****************************************
  logic [31:0] d_q, d_r, d_dv, q_t;
  logic [32:0] r_t;
  logic [5:0]  d_left, left_t;
  logic        d_nq, d_nr, d_slow;
  wire dsg   = op_req.op == op_divs;
  wire a_neg = dsg && op_req.a[31];
  wire b_neg = dsg && op_req.b[31];
  wire [5:0] steps = d_slow ? `DIV_STEPS_REV1 : `DIV_STEPS;
  always_comb
  begin
    r_t    = {1'h0, d_r};
    q_t    = d_q;
    left_t = d_left;
    for (int i = 0; i < 2; i++)
      if ((6'(i) < steps) && (left_t != 6'h00))
      begin
        r_t    = {r_t[31:0], q_t[31]};
        q_t    = {q_t[30:0], 1'h0};
        if (r_t >= {1'h0, d_dv})
        begin
          r_t    = r_t - {1'h0, d_dv};
          q_t[0] = 1'h1;
        end
        left_t = left_t - 6'h01;
      end
  end
  wire [63:0] div_res = {d_nr ? -d_r : d_r, d_nq ? -d_q : d_q};
  wire abort = (st_reg == st_div) && irq_pending;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {d_q, d_r, d_dv, d_left, d_nq, d_nr, d_slow} <= '0;
    else if (take)
    begin
      d_q    <= a_neg ? -op_req.a : op_req.a;
      d_dv   <= b_neg ? -op_req.b : op_req.b;
      d_r    <= 32'h0;
      d_left <= `DIV_BITS;
      d_nq   <= (a_neg ^ b_neg) && (op_req.b != 32'h0);
      d_nr   <= a_neg;
      d_slow <= rev1_reg;
    end
    else if (st_reg == st_div)
      {d_q, d_r, d_left} <= {q_t, r_t[31:0], left_t};
  end
  // ****************************************
  // sequencing
  // ****************************************
  wire fin   = !idle && (cnt_reg == 6'h01) && !abort;
  wire done1 = take && (lat_sel == `LAT_ONE);
  wire done  = done1 || fin;
  wire [63:0] res_w = (st_reg == st_div) ? div_res : fast_res;
  wire q_clr = pready_reg && penable && psel && pwrite && (paddr == `ADDR_STAT)
               && pwdata[`STAT_Q_BIT];
  wire q_set_w = done && fast_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg  <= st_idle;
      cnt_reg <= 6'h00;
      {busy_reg, valid_reg, qset_reg, abort_reg, q_reg} <= '0;
    end
    else
    begin
      st_reg    <= (take && !done1) ? (is_div ? st_div : st_wait) : (fin || abort) ? st_idle : st_reg;
      cnt_reg   <= take ? lat_sel - 6'h01 : idle ? cnt_reg : cnt_reg - 6'h01;
      busy_reg  <= (take && !done1) || (!idle && !fin && !abort);
      valid_reg <= done;
      qset_reg  <= q_set_w;
      abort_reg <= abort;
      q_reg     <= (q_reg && !q_clr) || q_set_w;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {req_reg, acc_reg, plo_reg, result_reg} <= '0;
    else
    begin
      if (take)
        {req_reg, acc_reg, plo_reg} <= {op_req, acc_src, plo};
      if (done)
        result_reg.value <= res_w;
    end
  end
  // accumulator cache follows the last accumulate result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {acc_cache_reg, acc_idx_reg, accv_reg} <= '0;
    else if (done && is_mac)
      {acc_cache_reg, acc_idx_reg, accv_reg} <= {res_w, cur.acc_idx, 1'h1};
    else if (acc_invalidate)
      accv_reg <= 1'h0;
  end
  // ****************************************
  // apb slave
  // ****************************************
  wire sel_ctrl = paddr == `ADDR_CTRL;
  wire sel_stat = paddr == `ADDR_STAT;
  wire setup    = psel && !penable;
  wire [31:0] rd_w = sel_ctrl ? {31'h0, rev1_reg}
                   : sel_stat ? {29'h0, accv_reg, busy_reg, q_reg} : 32'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {pready_reg, pslverr_reg, prdata_reg} <= '0;
      rev1_reg <= `CTRL_RST;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !(sel_ctrl || sel_stat);
      prdata_reg  <= setup ? rd_w : prdata_reg;
      if (pready_reg && penable && psel && pwrite && sel_ctrl)
        rev1_reg <= pwdata[`CTRL_REV1_BIT];
    end
  end
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign busy         = busy_reg;
  assign result_valid = valid_reg;
  assign result       = result_reg;
  assign q_flag       = q_reg;
  assign q_set        = qset_reg;
  assign div_abort    = abort_reg;
  // ****************************************
  // checks
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cyc_reg <= 6'h00;
    else
      div_cyc_reg <= (take && is_div) ? 6'h01 : (st_reg == st_div) ? div_cyc_reg + 6'h01 : 6'h00;
  end
  sequence s_two;
    busy_reg && !result_valid ##1 result_valid && !busy_reg;
  endsequence
  a_hh_issue: assert property (take && (op_req.op inside {op_mulhh, op_mulnhh})
    |=> result_valid && !busy_reg) else $error("halfword multiply not single cycle");
  a_wh_issue: assert property (take && (op_req.op == op_mulwh)
    |=> result_valid && (result.value[47:0] == $past(p_wh))) else $error("bad wh product");
  a_rnd_add: assert property (take && op_req.op == op_mulrndhh
    |=> result.value[31:0] == $past(p_hh) + 32'h0000_8000) else $error("rounding missing");
  a_mac_hit: assert property (take && is_mac && hit && !(op_req.op inside {op_macs_d, op_macu_d})
    |=> result_valid && !busy_reg) else $error("cached mac not one cycle");
  a_mac_miss: assert property (take && !hit && (op_req.op == op_mac) |=> s_two)
    else $error("uncached mac not two cycles");
  a_mul64_two: assert property (take && (op_req.op inside {op_muls_d, op_mulu_d}) |=> s_two)
    else $error("64-bit multiply not two cycles");
  a_mac64_hit: assert property (take && hit && (op_req.op inside {op_macs_d, op_macu_d})
    |=> busy_reg [*2] ##1 result_valid) else $error("64-bit mac hit not three cycles");
  a_div_fast: assert property (result_valid && $past(st_reg) == st_div && !$past(d_slow)
    |-> div_cyc_reg == `LAT_DIV) else $error("divide latency wrong");
  a_div_slow: assert property (result_valid && $past(st_reg) == st_div && $past(d_slow)
    |-> div_cyc_reg == `LAT_DIV_REV1) else $error("slow divide latency wrong");
  a_div_abort: assert property (st_reg == st_div && irq_pending
    |=> !busy_reg && div_abort && !result_valid) else $error("divide not abandoned");
  a_sat_clamp: assert property (take && op_req.op == op_satadd_w
    && op_req.a == 32'h7FFF_FFFF && !op_req.b[31] && op_req.b != 32'h0
    |=> result.value[31:0] == 32'h7FFF_FFFF && q_flag) else $error("no clamp on overflow");
  a_satrnd_two: assert property (take && (op_req.op inside {op_satrnds, op_satrndu}) |=> s_two)
    else $error("rounding saturate not two cycles");
  a_plain_flags: assert property (take && (op_req.op inside {op_mul, op_mulhh, op_mulwh})
    |=> !q_set) else $error("plain multiply touched flag");
  a_q_sticky: assert property (q_flag && !q_clr |=> q_flag) else $error("flag lost");
endmodule

// File: test/pipe_model.sv
// core pipeline model: issues ops, holds accumulators, raises interrupts
`timescale 1ns/10ps
module pipe_model
  import mmds_pkg::*;
(
  input  logic pclk,
  input  logic result_valid,
  input  res_t result,
  input  logic q_set,
  input  logic div_abort,
  output logic op_valid,
  output req_t op_req,
  output logic irq_pending,
  output logic acc_invalidate
);
  logic [63:0] acc_file [16];
  initial
  begin
    op_valid = 1'h0;
    op_req = '0;
    irq_pending = 1'h0;
    acc_invalidate = 1'h0;
    foreach (acc_file[k]) acc_file[k] = 64'h0;
  end
  // register file write drops the cached accumulator
  task automatic wr_acc(input logic [3:0] i, input logic [63:0] d);
    @(posedge pclk);
    acc_file[i] = d;
    acc_invalidate <= 1'h1;
    @(posedge pclk);
    acc_invalidate <= 1'h0;
  endtask
  // one op: take, wait for result or abort, write accumulates back
  task automatic issue(input req_t r, input int ab_at, output res_t v, output int lat,
                       output logic q, output logic ab);
    req_t t;
    t = r;
    t.acc = acc_file[r.acc_idx];
    @(posedge pclk);
    op_req <= t;
    op_valid <= 1'h1;
    irq_pending <= 1'h0;
    @(posedge pclk);
    op_valid <= 1'h0;
    lat = 1;
    #1;
    while (result_valid !== 1'h1 && div_abort !== 1'h1 && lat < 60)
    begin
      @(posedge pclk);
      if (lat == ab_at) irq_pending <= 1'h1;
      lat++;
      #1;
    end
    v = result;
    q = q_set;
    ab = div_abort;
    if (result_valid === 1'h1 && r.op inside {op_mac, op_machh_w, op_machh_d, op_macwh_d,
        op_macsathh_w, op_macs_d, op_macu_d}) acc_file[r.acc_idx] = result.value;
  endtask
endmodule

// File: test/tb.sv
// self-checking testbench of the arithmetic unit
`timescale 1ns/10ps
module tb
  import mmds_pkg::*;
;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, q, ab;
  logic        op_valid, irq_pending, acc_invalidate, busy, result_valid, q_flag, q_set;
  logic        div_abort;
  req_t        op_req, r;
  res_t        result, v;
  int          errors = 0;
  int          cmp_count = 0;
  int          lat;
  always #25 pclk = ~pclk;
  mul_mac_div_sat_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_req(op_req),
    .irq_pending(irq_pending), .acc_invalidate(acc_invalidate), .busy(busy),
    .result_valid(result_valid), .result(result), .q_flag(q_flag), .q_set(q_set),
    .div_abort(div_abort));
  pipe_model i_pipe (.pclk(pclk), .result_valid(result_valid), .result(result),
    .q_set(q_set), .div_abort(div_abort), .op_valid(op_valid), .op_req(op_req),
    .irq_pending(irq_pending), .acc_invalidate(acc_invalidate));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // f = {acc_idx[3:0], part_x, part_y, shift_amount[4:0], saturate_bit_field[4:0]}
  task automatic run(input op_t o, input logic [31:0] a, input logic [31:0] b,
                     input logic [15:0] f, input logic [63:0] ev, input int el,
                     input logic eq);
    r = '{o, a, b, 64'h0, f[15:12], f[11], f[10], f[9:5], f[4:0]};
    i_pipe.issue(r, 0, v, lat, q, ab);
    check(v.value, ev, o.name());
    check(64'(lat), 64'(el), "latency");
    check({63'h0, q}, {63'h0, eq}, "q_set");
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    run(op_mul, 32'h7, 32'h6, 16'h0, 64'h2A, 1, 1'h0);
    run(op_mulhh, 32'h30000, 32'hFFFE, 16'h800, 64'hFFFFFFFA, 1, 1'h0);
    run(op_mulnhh, 32'h30000, 32'hFFFE, 16'h800, 64'h6, 1, 1'h0);
    run(op_mulrndhh, 32'h2, 32'h3, 16'h0, 64'h8006, 1, 1'h0);
    run(op_mulwh, 32'hFFFFFFFF, 32'h2, 16'h0, 64'hFFFFFFFFFFFFFFFE, 1, 1'h0);
    run(op_mulnwh, 32'hFFFFFFFF, 32'h2, 16'h0, 64'h2, 1, 1'h0);
    run(op_muls_d, 32'hFFFFFFFF, 32'hFFFFFFFF, 16'h0, 64'h1, 2, 1'h0);
    run(op_mulu_d, 32'hFFFFFFFF, 32'hFFFFFFFF, 16'h0, 64'hFFFFFFFE00000001, 2, 1'h0);
    check({63'h0, q_flag}, 64'h0, "q_flag");
    $display("test multiply done");
    i_pipe.wr_acc(4'h1, 64'hA);
    run(op_mac, 32'h2, 32'h3, 16'h1000, 64'h10, 2, 1'h0);
    run(op_mac, 32'h2, 32'h3, 16'h1000, 64'h16, 1, 1'h0);
    i_pipe.wr_acc(4'h1, 64'h64);
    run(op_mac, 32'h2, 32'h3, 16'h1000, 64'h6A, 2, 1'h0);
    run(op_machh_w, 32'h20000, 32'h3, 16'h1800, 64'h70, 1, 1'h0);
    run(op_machh_d, 32'hFFFF, 32'h5, 16'h3000, 64'hFFFFFFFFFFFFFFFB, 2, 1'h0);
    run(op_macwh_d, 32'hFFFFFFFF, 32'h2, 16'h3000, 64'hFFFFFFFFFFFFFFF9, 1, 1'h0);
    i_pipe.wr_acc(4'h5, 64'h5);
    run(op_macs_d, 32'hFFFFFFFF, 32'h3, 16'h5000, 64'h2, 4, 1'h0);
    run(op_macs_d, 32'hFFFFFFFF, 32'h3, 16'h5000, 64'hFFFFFFFFFFFFFFFF, 3, 1'h0);
    run(op_macu_d, 32'hFFFFFFFF, 32'h2, 16'h5000, 64'h1FFFFFFFD, 3, 1'h0);
    check({63'h0, q_flag}, 64'h0, "q_flag");
    $display("test accumulate done");
    run(op_divs, 32'hFFFFFFF9, 32'h2, 16'h0, 64'hFFFFFFFFFFFFFFFD, 19, 1'h0);
    run(op_divu, 32'h7, 32'h2, 16'h0, 64'h100000003, 19, 1'h0);
    apb(1'h1, 12'h000, 32'h1);
    run(op_divu, 32'h64, 32'h7, 16'h0, 64'h20000000E, 35, 1'h0);
    apb(1'h1, 12'h000, 32'h0);
    r = '{op_divu, 32'h64, 32'h7, 64'h0, 4'h0, 1'h0, 1'h0, 5'h0, 5'h0};
    i_pipe.issue(r, 5, v, lat, q, ab);
    check({63'h0, ab}, 64'h1, "div_abort");
    check(v.value, 64'h20000000E, "result kept");
    check(64'(lat < 19), 64'h1, "abort early");
    check({63'h0, busy}, 64'h0, "busy after abort");
    $display("test divide done");
    run(op_mulsathh_h, 32'h8000, 32'h8000, 16'h0, 64'h7FFF, 1, 1'h1);
    run(op_mulsathh_w, 32'h8000, 32'h8000, 16'h0, 64'h7FFFFFFF, 1, 1'h1);
    run(op_mulsatwh_w, 32'h80000000, 32'h8000, 16'h0, 64'h7FFFFFFF, 1, 1'h1);
    run(op_mulsatrndhh_h, 32'h4000, 32'h4000, 16'h0, 64'h2000, 1, 1'h0);
    run(op_mulsatrndwh_w, 32'h40000000, 32'h4000, 16'h0, 64'h20000000, 1, 1'h0);
    i_pipe.wr_acc(4'h4, 64'h7FFFFFF0);
    run(op_macsathh_w, 32'h4000, 32'h4000, 16'h4000, 64'h7FFFFFFF, 2, 1'h1);
    run(op_satadd_w, 32'h7FFFFFFF, 32'h1, 16'h0, 64'h7FFFFFFF, 1, 1'h1);
    run(op_satsub_w, 32'h80000000, 32'h1, 16'h0, 64'h80000000, 1, 1'h1);
    run(op_satadd_w, 32'h1, 32'h2, 16'h0, 64'h3, 1, 1'h0);
    run(op_satadd_h, 32'h7FFF0001, 32'h10001, 16'h0, 64'h7FFF0002, 1, 1'h1);
    run(op_satsub_h, 32'h80000005, 32'h10001, 16'h0, 64'h80000004, 1, 1'h1);
    run(op_sats, 32'h1000, 32'h0, 16'h88, 64'h7F, 1, 1'h1);
    run(op_satu, 32'hFFFFFFF0, 32'h0, 16'h8, 64'h0, 1, 1'h1);
    run(op_sats, 32'hFFFFFF00, 32'h0, 16'h88, 64'hFFFFFFF0, 1, 1'h0);
    run(op_satrnds, 32'h7, 32'h0, 16'h28, 64'h4, 2, 1'h0);
    run(op_satrndu, 32'h3FF, 32'h0, 16'h28, 64'hFF, 2, 1'h1);
    check({63'h0, q_flag}, 64'h1, "q_flag");
    apb(1'h0, 12'h004, 32'h0);
    check({63'h0, rd[0]}, 64'h1, "status q");
    check({62'h0, rd[2:1]}, 64'h2, "status cache busy");
    apb(1'h1, 12'h004, 32'h1);
    @(posedge pclk);
    #1;
    check({63'h0, q_flag}, 64'h0, "q cleared");
    apb(1'h0, 12'h010, 32'h0);
    check({31'h0, er, rd}, 64'h100000000, "unmapped");
    $display("test saturate done");
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule
